// >>> core/lfcs_store.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "lfcs_regs.svh"
module lfcs_store #(
  parameter int FLASH_WORD_BITS = 5,
  parameter int FLASH_PAGE_BITS = 7,
  parameter int EE_ADDR_BITS = 9,
  // arbitrary identification values
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,
  parameter logic [7:0] SIG_BYTE1 = 8'ha5,
  parameter logic [7:0] SIG_BYTE2 = 8'h3c,
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // programming session
  input wire logic prog_mode_i,
  input wire logic prog_serial_i,
  input wire logic cmd_valid_i,
  input wire lfcs_pkg::lfcs_cmd_e cmd_i,
  input wire lfcs_pkg::lfcs_mem_e mem_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  // answers
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic refused_o,
  // memory array requests
  output logic mem_wr_o,
  output logic mem_rd_o,
  output logic mem_sel_eeprom_o,
  output logic [FLASH_WORD_BITS-1:0] word_in_page_field_o,
  output logic [FLASH_PAGE_BITS-1:0] page_number_field_o,
  output logic [EE_ADDR_BITS-1:0] eeprom_address_bits_o,
  output logic flash_erase_o,
  output logic eeprom_erase_o,
  // cpu side
  input wire logic store_program_memory_instruction_i,
  output logic store_program_allow_o,
  output logic [7:0] oscillator_calibration_register_o,
  // working fuse values
  output logic [7:0] fuse_low_o,
  output logic [7:0] fuse_high_o,
  output logic [7:0] fuse_ext_o,
  output logic [1:0] lock_bits_o,
  output logic clock_output_enable_o
);
  // ----------------------------------------
  // stored bytes
  // ----------------------------------------
  logic [7:0] lock_q;
  logic [7:0] nv_q [4];
  logic [7:0] latch_q [3];
  logic prog_mode_q;
  logic powered_q;
  lfcs_pkg::lfcs_mode_e mode;
  logic fuse_locked;
  logic [FLASH_WORD_BITS-1:0] word_d;
  logic [FLASH_PAGE_BITS-1:0] page_d;
  logic [`LFCS_EE_BYTE_BITS-1:0] ee_byte;
  logic [EE_ADDR_BITS-`LFCS_EE_BYTE_BITS-1:0] ee_page;
  logic do_erase;
  logic do_fuse_wr;
  logic do_lock_wr;
  logic mem_wr_ok;
  logic mem_rd_ok;
  logic [7:0] fuse_wdata;

  lfcs_mode_decode u_mode (
    .lock_i(lock_q),
    .mode_o(mode),
    .fuse_locked_o(fuse_locked)
  );

  lfcs_geometry #(
    .FLASH_WORD_BITS(FLASH_WORD_BITS),
    .FLASH_PAGE_BITS(FLASH_PAGE_BITS),
    .EE_ADDR_BITS(EE_ADDR_BITS)
  ) u_geom (
    .addr_i(addr_i),
    .word_in_page_field_o(word_d),
    .page_number_field_o(page_d),
    .ee_byte_o(ee_byte),
    .ee_page_o(ee_page)
  );

  // ----------------------------------------
  // request gating
  // ----------------------------------------
  function automatic logic is_cmd(input lfcs_pkg::lfcs_cmd_e c);
    is_cmd = cmd_valid_i && prog_mode_i && (cmd_i == c);
  endfunction : is_cmd

  always_comb begin
    do_erase = is_cmd(lfcs_pkg::LFCS_CMD_CHIP_ERASE);
    do_fuse_wr = is_cmd(lfcs_pkg::LFCS_CMD_WRITE_FUSE) && !fuse_locked; // [R5] [R6]
    do_lock_wr = is_cmd(lfcs_pkg::LFCS_CMD_WRITE_LOCK);
    mem_wr_ok = is_cmd(lfcs_pkg::LFCS_CMD_WRITE_MEM) &&
                (mode == lfcs_pkg::LFCS_MODE_OPEN); // [R24] [R4] [R5]
    mem_rd_ok = is_cmd(lfcs_pkg::LFCS_CMD_READ_MEM) &&
                (mode != lfcs_pkg::LFCS_MODE_FULLLOCK); // [R24] [R6]
    fuse_wdata = wdata_i;
    if (prog_serial_i && sel_i == `LFCS_SEL_HIGH) begin
      fuse_wdata[`LFCS_HIGH_SERIAL_BIT] = nv_q[`LFCS_SEL_HIGH][`LFCS_HIGH_SERIAL_BIT]; // [R10]
    end
  end

  // ----------------------------------------
  // lock byte
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= `LFCS_LOCK_RESET;
    end else if (do_erase) begin
      lock_q <= `LFCS_LOCK_RESET; // [R2]
    end else if (do_lock_wr) begin
      lock_q <= {6'h3f, lock_q[1:0] & wdata_i[1:0]}; // [R1] [R2]
    end
  end

  // ----------------------------------------
  // nonvolatile fuse bytes
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_q[`LFCS_SEL_LOW] <= `LFCS_LOW_RESET; // [R13]
      nv_q[`LFCS_SEL_HIGH] <= `LFCS_HIGH_RESET; // [R8]
      nv_q[`LFCS_SEL_EXT] <= `LFCS_EXT_RESET; // [R7]
      nv_q[`LFCS_SEL_LOCK] <= `LFCS_BYTE_ERASED;
    end else if (do_fuse_wr && sel_i != `LFCS_SEL_LOCK) begin
      nv_q[sel_i] <= fuse_wdata; // [R7] [R15]
    end
  end

  // ----------------------------------------
  // working latches
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_mode_q <= 1'b0;
      powered_q <= 1'b0;
    end else begin
      prog_mode_q <= prog_mode_i;
      powered_q <= 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_latch
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          latch_q[i] <= `LFCS_BYTE_ERASED;
        end else if (!powered_q || (prog_mode_i && !prog_mode_q)) begin
          latch_q[i] <= nv_q[i]; // [R17] [R19]
        end else if (!prog_mode_i && prog_mode_q) begin
          latch_q[i] <= nv_q[i]; // [R17]
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // memory requests and erase
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_sel_eeprom_o <= 1'b0;
      word_in_page_field_o <= '0;
      page_number_field_o <= '0;
      eeprom_address_bits_o <= '0;
      flash_erase_o <= 1'b0;
      eeprom_erase_o <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      mem_wr_o <= mem_wr_ok;
      mem_rd_o <= mem_rd_ok;
      mem_sel_eeprom_o <= (mem_i == lfcs_pkg::LFCS_MEM_EEPROM);
      word_in_page_field_o <= word_d; // [R22]
      page_number_field_o <= page_d; // [R22]
      eeprom_address_bits_o <= {ee_page, ee_byte}; // [R23]
      flash_erase_o <= do_erase;
      // preserve fuse read directly from store, not latch
      eeprom_erase_o <= do_erase &&
        nv_q[`LFCS_SEL_HIGH][`LFCS_HIGH_PRESERVE_BIT]; // [R9] [R18]
      refused_o <= (is_cmd(lfcs_pkg::LFCS_CMD_WRITE_MEM) && !mem_wr_ok) ||
                   (is_cmd(lfcs_pkg::LFCS_CMD_READ_MEM) && !mem_rd_ok) ||
                   (is_cmd(lfcs_pkg::LFCS_CMD_WRITE_FUSE) && fuse_locked); // [R24]
    end
  end

  // ----------------------------------------
  // read answers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= is_cmd(lfcs_pkg::LFCS_CMD_READ_SIG) || is_cmd(lfcs_pkg::LFCS_CMD_READ_FUSE);
      if (is_cmd(lfcs_pkg::LFCS_CMD_READ_SIG)) begin
        unique case (addr_i[1:0])
          `LFCS_SIG_ADDR0: rdata_o <= sel_i[0] ? CAL_BYTE : SIG_BYTE0; // [R20] [R21]
          `LFCS_SIG_ADDR1: rdata_o <= SIG_BYTE1; // [R20]
          `LFCS_SIG_ADDR2: rdata_o <= SIG_BYTE2; // [R20]
          default: rdata_o <= 8'h00;
        endcase
      end else if (is_cmd(lfcs_pkg::LFCS_CMD_READ_FUSE)) begin
        rdata_o <= (sel_i == `LFCS_SEL_LOCK) ? lock_q : nv_q[sel_i]; // [R1] [R7]
      end
    end
  end

  // ----------------------------------------
  // working outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oscillator_calibration_register_o <= CAL_BYTE; // [R21]
      fuse_low_o <= `LFCS_LOW_RESET;
      fuse_high_o <= `LFCS_HIGH_RESET;
      fuse_ext_o <= `LFCS_EXT_RESET;
      lock_bits_o <= 2'h3;
      store_program_allow_o <= 1'b0;
      clock_output_enable_o <= 1'b0;
    end else begin
      oscillator_calibration_register_o <= oscillator_calibration_register_o;
      fuse_low_o <= latch_q[`LFCS_SEL_LOW];
      fuse_high_o <= latch_q[`LFCS_SEL_HIGH];
      fuse_ext_o <= latch_q[`LFCS_SEL_EXT];
      lock_bits_o <= lock_q[1:0];
      store_program_allow_o <= store_program_memory_instruction_i &&
        !latch_q[`LFCS_SEL_EXT][`LFCS_EXT_SELFPRG_BIT]; // [R3]
      clock_output_enable_o <= !latch_q[`LFCS_SEL_LOW][`LFCS_LOW_CLOCK_OUTPUT_FUSE_BIT]; // [R14]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_lock_erase_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (!do_erase) |=> ((lock_q[1:0] & ~$past(lock_q[1:0])) == 2'h0)) // [R2]
    else $error("lock bit returned to one without erase");
  a_erase_lock_one: assert property (@(posedge clk_i) disable iff (rst_i)
    do_erase |=> lock_q == `LFCS_LOCK_RESET) // [R2]
    else $error("erase did not clear lock");
  a_fuse_locked_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (fuse_locked && !powered_q == 1'b0) |=> $stable(nv_q[`LFCS_SEL_HIGH])) // [R5]
    else $error("fuse changed while locked");
  a_wrlock_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_cmd(lfcs_pkg::LFCS_CMD_WRITE_MEM) && mode != lfcs_pkg::LFCS_MODE_OPEN)
      |=> !mem_wr_o && refused_o) // [R5]
    else $error("write passed in locked mode");
  a_full_noread: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == lfcs_pkg::LFCS_MODE_FULLLOCK) |=> !mem_rd_o) // [R6]
    else $error("read passed in full lock");
  a_erase_keep_fuse: assert property (@(posedge clk_i) disable iff (rst_i)
    do_erase |=> $stable(nv_q[`LFCS_SEL_LOW])) // [R15]
    else $error("erase changed fuses");
  a_ee_erase_save: assert property (@(posedge clk_i) disable iff (rst_i)
    do_erase |=> eeprom_erase_o == $past(nv_q[`LFCS_SEL_HIGH][`LFCS_HIGH_PRESERVE_BIT])) // [R9]
    else $error("eeprom erase wrong");
  a_sig_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cmd(lfcs_pkg::LFCS_CMD_READ_SIG) |=> rvalid_o) // [R20]
    else $error("signature not answered");
  a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (powered_q && prog_mode_i && prog_mode_q) |=> $stable(latch_q[`LFCS_SEL_LOW])) // [R17]
    else $error("latch moved during programming");
  a_clkout: assert property (@(posedge clk_i) disable iff (rst_i)
    powered_q |=> clock_output_enable_o == !fuse_low_o[`LFCS_LOW_CLOCK_OUTPUT_FUSE_BIT]) // [R14]
    else $error("clock output mismatch");
endmodule : lfcs_store

// >>> core/lfcs_regs.svh
`ifndef LFCS_REGS_SVH
`define LFCS_REGS_SVH
// Contract
// [R1] two lock bits, bits 1:0, upper ones
// [R2] only chip erase returns lock bits to one
// [R3] store program allowed when self-program fuse zero
// [R4] mode 1 applies no restrictions
// [R5] mode 2 blocks programming, locks fuses
// [R6] mode 3 blocks programming, verify, fuses
// [R7] three fuse bytes, programmed reads zero
// [R8] high fuse field positions and defaults
// [R9] unpreserved eeprom erased by chip erase
// [R10] serial path cannot reach serial-enable fuse
// [R11] programmer keeps debug fuse unprogrammed
// [R12] after reset-disable, fuses need high voltage; the store takes serial fuse writes whatever LFCS_HIGH_RSTDIS_BIT holds
// [R13] low fuse defaults select internal rc
// [R14] clock output fuse drives port b5
// [R15] chip erase leaves fuses unchanged
// [R16] programmer writes fuses before lock bits
// [R17] fuses latched at programming mode entry
// [R18] eeprom preserve acts immediately once programmed
// [R19] fuses latched at power-up too
// [R20] three signature bytes readable even locked
// [R21] calibration byte loaded on every reset
// [R22] flash page geometry per variant
// [R23] eeprom four-byte pages, variant totals
// [R24] protection mode decoded for every request

// ----------------------------------------
// field positions
// ----------------------------------------
`define LFCS_LOCK_LOW_BIT 0
`define LFCS_LOCK_HIGH_BIT 1
`define LFCS_EXT_SELFPRG_BIT 0
`define LFCS_HIGH_RSTDIS_BIT 7
`define LFCS_HIGH_DEBUG_BIT 6
`define LFCS_HIGH_SERIAL_BIT 5
`define LFCS_HIGH_WDT_BIT 4
`define LFCS_HIGH_PRESERVE_BIT 3
`define LFCS_LOW_CLOCK_OUTPUT_FUSE_BIT 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define LFCS_LOCK_RESET 8'hff
`define LFCS_EXT_RESET 8'hff
`define LFCS_HIGH_RESET 8'hdf
`define LFCS_LOW_RESET 8'h62
`define LFCS_BYTE_ERASED 8'hff

// ----------------------------------------
// selectors and addresses
// ----------------------------------------
`define LFCS_SEL_LOW 2'h0
`define LFCS_SEL_HIGH 2'h1
`define LFCS_SEL_EXT 2'h2
`define LFCS_SEL_LOCK 2'h3
`define LFCS_SIG_ADDR0 2'h0
`define LFCS_SIG_ADDR1 2'h1
`define LFCS_SIG_ADDR2 2'h2
`define LFCS_EE_BYTE_BITS 2
`endif

// >>> core/lfcs_pkg.sv
package lfcs_pkg;
  typedef enum logic [1:0] {
    LFCS_MODE_OPEN,
    LFCS_MODE_WRLOCK,
    LFCS_MODE_FULLLOCK
  } lfcs_mode_e;

  typedef enum logic [2:0] {
    LFCS_CMD_NONE,
    LFCS_CMD_CHIP_ERASE,
    LFCS_CMD_WRITE_FUSE,
    LFCS_CMD_WRITE_LOCK,
    LFCS_CMD_WRITE_MEM,
    LFCS_CMD_READ_MEM,
    LFCS_CMD_READ_SIG,
    LFCS_CMD_READ_FUSE
  } lfcs_cmd_e;

  typedef enum logic {
    LFCS_MEM_FLASH,
    LFCS_MEM_EEPROM
  } lfcs_mem_e;
endpackage : lfcs_pkg

// >>> core/lfcs_mode_decode.sv
`timescale 1ns/10ps
`include "lfcs_regs.svh"
module lfcs_mode_decode (
  // lock byte
  input wire logic [7:0] lock_i,
  // decoded mode
  output lfcs_pkg::lfcs_mode_e mode_o,
  output logic fuse_locked_o
);
  // ----------------------------------------
  // protection mode
  // ----------------------------------------
  always_comb begin
    if (!lock_i[`LFCS_LOCK_LOW_BIT] && !lock_i[`LFCS_LOCK_HIGH_BIT]) begin
      mode_o = lfcs_pkg::LFCS_MODE_FULLLOCK; // [R6]
    end else if (!lock_i[`LFCS_LOCK_LOW_BIT]) begin
      mode_o = lfcs_pkg::LFCS_MODE_WRLOCK; // [R5]
    end else begin
      mode_o = lfcs_pkg::LFCS_MODE_OPEN; // [R4]
    end
    fuse_locked_o = !lock_i[`LFCS_LOCK_LOW_BIT]; // [R5] [R6]
  end
endmodule : lfcs_mode_decode

// >>> core/lfcs_geometry.sv
`timescale 1ns/10ps
`include "lfcs_regs.svh"
module lfcs_geometry #(
  parameter int FLASH_WORD_BITS = 5,
  parameter int FLASH_PAGE_BITS = 7,
  parameter int EE_ADDR_BITS = 9
) (
  // raw addresses
  input wire logic [15:0] addr_i,
  // split fields
  output logic [FLASH_WORD_BITS-1:0] word_in_page_field_o,
  output logic [FLASH_PAGE_BITS-1:0] page_number_field_o,
  output logic [`LFCS_EE_BYTE_BITS-1:0] ee_byte_o,
  output logic [EE_ADDR_BITS-`LFCS_EE_BYTE_BITS-1:0] ee_page_o
);
  // ----------------------------------------
  // page split
  // ----------------------------------------
  always_comb begin
    word_in_page_field_o = addr_i[FLASH_WORD_BITS-1:0]; // [R22]
    page_number_field_o = addr_i[FLASH_WORD_BITS+FLASH_PAGE_BITS-1:FLASH_WORD_BITS]; // [R22]
    ee_byte_o = addr_i[`LFCS_EE_BYTE_BITS-1:0]; // [R23]
    ee_page_o = addr_i[EE_ADDR_BITS-1:`LFCS_EE_BYTE_BITS]; // [R23]
  end
endmodule : lfcs_geometry

// >>> verification/lfcs_prog_model.sv
`timescale 1ns/10ps
// ----
// programmer on the far side of the store
// ----
module lfcs_prog_model (
  // clock
  input wire logic clk_i,
  // session and command lines
  output logic prog_mode_o,
  output logic prog_serial_o,
  output logic cmd_valid_o,
  output lfcs_pkg::lfcs_cmd_e cmd_o,
  output lfcs_pkg::lfcs_mem_e mem_o,
  output logic [1:0] sel_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    prog_mode_o = 1'b0;
    prog_serial_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_o = lfcs_pkg::LFCS_CMD_NONE;
    mem_o = lfcs_pkg::LFCS_MEM_FLASH;
    sel_o = 2'h0;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  // one command pulse, result sampled just after the next edge
  task send(input lfcs_pkg::lfcs_cmd_e c, input lfcs_pkg::lfcs_mem_e m, input logic [1:0] s,
            input logic [15:0] a, input logic [7:0] w);
    logic [7:0] wd;
    wd = w;
    if (c == lfcs_pkg::LFCS_CMD_WRITE_FUSE && s == 2'h1) begin
      wd = w | 8'hc0;
    end
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= c;
    mem_o <= m;
    sel_o <= s;
    addr_o <= a;
    wdata_o <= wd;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~wd;
    #1;
  endtask : send
  // enter or leave programming mode, then let the latches settle
  task mode(input logic m, input logic s);
    @(posedge clk_i);
    prog_mode_o <= m;
    prog_serial_o <= s;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : mode
endmodule : lfcs_prog_model

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    lfcs_pkg::lfcs_cmd_e c;
    logic [1:0] s;
    logic [15:0] a;
    logic [7:0] e;
  } lfcs_row_s;
  localparam logic [7:0] S0 = 8'h5a;
  localparam logic [7:0] S1 = 8'ha5;
  localparam logic [7:0] S2 = 8'h3c;
  localparam logic [7:0] CAL = 8'h80;
  localparam lfcs_pkg::lfcs_cmd_e RS = lfcs_pkg::LFCS_CMD_READ_SIG;
  localparam lfcs_pkg::lfcs_cmd_e RF = lfcs_pkg::LFCS_CMD_READ_FUSE;
  localparam lfcs_pkg::lfcs_cmd_e WF = lfcs_pkg::LFCS_CMD_WRITE_FUSE;
  localparam lfcs_pkg::lfcs_cmd_e WL = lfcs_pkg::LFCS_CMD_WRITE_LOCK;
  localparam lfcs_pkg::lfcs_cmd_e WM = lfcs_pkg::LFCS_CMD_WRITE_MEM;
  localparam lfcs_pkg::lfcs_cmd_e RM = lfcs_pkg::LFCS_CMD_READ_MEM;
  localparam lfcs_pkg::lfcs_cmd_e CE = lfcs_pkg::LFCS_CMD_CHIP_ERASE;
  localparam lfcs_pkg::lfcs_mem_e FL = lfcs_pkg::LFCS_MEM_FLASH;
  localparam lfcs_pkg::lfcs_mem_e EE = lfcs_pkg::LFCS_MEM_EEPROM;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic spm_i = 1'b1;
  logic pm, ps, cv, rv, rf, mw, mr, mse, fe, ee, spa, coe;
  lfcs_pkg::lfcs_cmd_e cmd;
  lfcs_pkg::lfcs_mem_e mem;
  logic [1:0] sel, lk;
  logic [15:0] addr;
  logic [7:0] wd, rd, cal, fl, fh, fx;
  logic [4:0] wp;
  logic [6:0] pg;
  logic [8:0] ea;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  lfcs_row_s tab [10] = '{
    '{RS, 2'h0, 16'h0000, S0}, '{RS, 2'h0, 16'h0001, S1},
    '{RS, 2'h0, 16'h0002, S2}, '{RS, 2'h1, 16'h0000, CAL},
    '{RF, 2'h0, 16'h0000, 8'h62}, '{RF, 2'h1, 16'h0000, 8'hdf},
    '{RF, 2'h2, 16'h0000, 8'hff}, '{RF, 2'h3, 16'h0000, 8'hff},
    '{WM, 2'h0, 16'h0010, 8'h00}, '{RM, 2'h0, 16'h0011, 8'h00}};
  always #50 clk_i = ~clk_i;
  lfcs_prog_model prg (.clk_i(clk_i), .prog_mode_o(pm), .prog_serial_o(ps), .cmd_valid_o(cv),
    .cmd_o(cmd), .mem_o(mem), .sel_o(sel), .addr_o(addr), .wdata_o(wd));
  lfcs_store #(.SIG_BYTE0(S0), .SIG_BYTE1(S1), .SIG_BYTE2(S2), .CAL_BYTE(CAL)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .prog_mode_i(pm), .prog_serial_i(ps), .cmd_valid_i(cv),
    .cmd_i(cmd), .mem_i(mem), .sel_i(sel), .addr_i(addr), .wdata_i(wd), .rdata_o(rd),
    .rvalid_o(rv), .refused_o(rf), .mem_wr_o(mw), .mem_rd_o(mr), .mem_sel_eeprom_o(mse),
    .word_in_page_field_o(wp), .page_number_field_o(pg), .eeprom_address_bits_o(ea),
    .flash_erase_o(fe), .eeprom_erase_o(ee), .store_program_memory_instruction_i(spm_i),
    .store_program_allow_o(spa), .oscillator_calibration_register_o(cal), .fuse_low_o(fl),
    .fuse_high_o(fh), .fuse_ext_o(fx), .lock_bits_o(lk), .clock_output_enable_o(coe));
  task chk(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // one command with its generic checks
  task go(input lfcs_pkg::lfcs_cmd_e c, input lfcs_pkg::lfcs_mem_e m, input logic [1:0] s,
          input logic [15:0] a, input logic [7:0] w, input logic f, input logic [7:0] e);
    prg.send(c, m, s, a, w);
    chk({7'h0, rf}, {7'h0, f});
    if (c == RS || c == RF) chk(rd, e);
    if (c == WM) chk({7'h0, mw}, {7'h0, !f});
    if (c == RM) chk({7'h0, mr}, {7'h0, !f});
  endtask : go
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(fl, 8'h62);
    chk(fh, 8'hdf);
    chk(fx, 8'hff);
    chk({6'h3f, lk}, 8'hff);
    chk(cal, CAL);
    chk({6'h0, spa, coe}, 8'h00);
    $display("test defaults done");
    prg.mode(1'b1, 1'b0);
    foreach (tab[i]) go(tab[i].c, FL, tab[i].s, tab[i].a, 8'h00, 1'b0, tab[i].e);
    $display("test table done");
    go(WM, FL, 2'h0, 16'h0abc, 8'h12, 1'b0, 8'h00);
    chk({3'h0, wp}, 8'h1c);
    chk({1'b0, pg}, 8'h55);
    go(WM, EE, 2'h0, 16'h01fe, 8'h34, 1'b0, 8'h00);
    chk(ea[7:0], 8'hfe);
    chk({7'h0, ea[8]}, 8'h01);
    go(CE, FL, 2'h0, 16'h0000, 8'h00, 1'b0, 8'h00);
    chk({6'h0, fe, ee}, 8'h03);
    // fuses first, lock bits later
    go(WF, FL, 2'h0, 16'h0000, 8'h22, 1'b0, 8'h00);
    go(WF, FL, 2'h2, 16'h0000, 8'hfe, 1'b0, 8'h00);
    go(WF, FL, 2'h1, 16'h0000, 8'hd7, 1'b0, 8'h00);
    chk(fl, 8'h62);
    chk({7'h0, coe}, 8'h00);
    go(CE, FL, 2'h0, 16'h0000, 8'h00, 1'b0, 8'h00);
    chk({6'h0, fe, ee}, 8'h02);
    prg.mode(1'b0, 1'b0);
    chk(fl, 8'h22);
    chk(fh, 8'hd7);
    chk({6'h0, spa, coe}, 8'h03);
    $display("test fuses done");
    prg.mode(1'b1, 1'b1);
    go(WF, FL, 2'h1, 16'h0000, 8'hff, 1'b0, 8'h00);
    prg.mode(1'b0, 1'b0);
    chk(fh, 8'hdf);
    $display("test serial done");
    prg.mode(1'b1, 1'b0);
    go(WL, FL, 2'h3, 16'h0000, 8'hfe, 1'b0, 8'h00);
    @(posedge clk_i);
    #1;
    chk({6'h0, lk}, 8'h02);
    go(WM, FL, 2'h0, 16'h0020, 8'h55, 1'b1, 8'h00);
    go(WM, EE, 2'h0, 16'h0004, 8'h55, 1'b1, 8'h00);
    go(RM, FL, 2'h0, 16'h0020, 8'h00, 1'b0, 8'h00);
    go(WF, FL, 2'h0, 16'h0000, 8'h62, 1'b1, 8'h00);
    go(RS, FL, 2'h0, 16'h0001, 8'h00, 1'b0, S1);
    go(WL, FL, 2'h3, 16'h0000, 8'hfc, 1'b0, 8'h00);
    go(RM, EE, 2'h0, 16'h0004, 8'h00, 1'b1, 8'h00);
    go(WF, FL, 2'h2, 16'h0000, 8'hff, 1'b1, 8'h00);
    go(RS, FL, 2'h0, 16'h0002, 8'h00, 1'b0, S2);
    go(WL, FL, 2'h3, 16'h0000, 8'hff, 1'b0, 8'h00);
    chk({6'h0, lk}, 8'h00);
    go(CE, FL, 2'h0, 16'h0000, 8'h00, 1'b0, 8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    chk({6'h0, lk}, 8'h03);
    go(WM, FL, 2'h0, 16'h0020, 8'h55, 1'b0, 8'h00);
    $display("test locks done");
    stop_test();
  end
endmodule : tb
